/* hw/ipc_top.sv */
// Interrupt priority, external pin and comparator edge configuration block
// Operation
// - Priority bits 7..0 belong to third timer, comparator B, comparator A, counter array, conversion done, window compare, usb function, two-wire port.
// - A priority bit of 0 means low level and 1 means high level.
// - The priority register resets to all zeros.
// - Comparator mode bit 5 enables the comparator B rising-edge interrupt.
// - Comparator mode bit 4 enables the comparator B falling-edge interrupt.
// - The comparator mode register resets to 0x02.
// - Pin config holds input B polarity in bit 7, its select in 6..4, input A polarity in bit 3, its select in 2..0.
// - The pin config register resets to 0x01.
// - Input B polarity 0 means active low, 1 active high.
// - Input monitoring only reads the selected pin and never drives it.
// - A pin whose skip bit is set is never handed to a peripheral.
// - Input A polarity 0 requests when low, 1 when high.
`timescale 1ns/100ps
`default_nettype none
module ipc_top #(
  parameter int NSRC = 8
) (
  // Clock, reset, enable
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic CLK_EN,
  // Avalon-MM slave
  input wire logic [7:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  output logic [1:0] AVS_RESPONSE,
  // Port 0 pins and routing
  input wire logic [7:0] PORT0_IN,
  input wire logic [7:0] PORT0_SKIP,
  input wire logic [7:0] PERIPH_WANT,
  output logic [7:0] PERIPH_GRANT,
  // Comparator B output and prioritised sources
  input wire logic CMP_B_OUT,
  input wire logic [NSRC-1:0] SRC_REQ,
  // Requests to the core
  output logic EXT_A_REQ,
  output logic EXT_B_REQ,
  output logic [NSRC-1:0] CORE_GRANT,
  output logic CORE_GRANT_HIGH,
  output logic [1:0] CMP_B_RESP_MODE,
  output logic IRQ
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0] cmp_b_mode;
  logic [7:0] ext_cfg;
  logic [NSRC-1:0] prio_one;
  logic [3:0] irq_status;
  logic [3:0] irq_mask;
  logic [3:0] next_status;
  logic [3:0] events;
  logic cmp_b_q;
  logic ext_a_act;
  logic ext_b_act;
  logic [NSRC-1:0] arb_grant;
  logic arb_high;
  ipc_pkg::ipc_bus_t bus_state;
  logic wr_hit;
  logic rd_hit;
  logic hit;
  logic [31:0] rd_mux;
  logic wr_lane;

  assign wr_lane = AVS_BYTEENABLE[0];
  assign hit = (AVS_ADDRESS == ipc_pkg::OFS_CMP_B_MODE) || (AVS_ADDRESS == ipc_pkg::OFS_EXT_CFG) ||
               (AVS_ADDRESS == ipc_pkg::OFS_PRIO_ONE) || (AVS_ADDRESS == ipc_pkg::OFS_IRQ_STATUS) ||
               (AVS_ADDRESS == ipc_pkg::OFS_IRQ_MASK) || (AVS_ADDRESS == ipc_pkg::OFS_REQ_PEND) ||
               (AVS_ADDRESS == ipc_pkg::OFS_GRANT);
  assign wr_hit = CLK_EN && AVS_WRITE && (bus_state == ipc_pkg::BUS_ACK) && wr_lane;
  assign rd_hit = CLK_EN && AVS_READ && (bus_state == ipc_pkg::BUS_ACK);

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: one wait cycle, answer in the second cycle
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      bus_state <= ipc_pkg::BUS_IDLE;
    end else if (CLK_EN) begin
      case (bus_state)
        ipc_pkg::BUS_IDLE: begin
          if (AVS_READ || AVS_WRITE) begin
            bus_state <= ipc_pkg::BUS_ACK;
          end
        end
        ipc_pkg::BUS_ACK: bus_state <= ipc_pkg::BUS_DONE;
        ipc_pkg::BUS_DONE: bus_state <= ipc_pkg::BUS_IDLE;
        default: bus_state <= ipc_pkg::BUS_IDLE;
      endcase
    end
  end

  assign AVS_WAITREQUEST = (bus_state != ipc_pkg::BUS_ACK) || !CLK_EN;

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (AVS_ADDRESS)
      ipc_pkg::OFS_CMP_B_MODE: rd_mux = {24'h00_0000, cmp_b_mode};
      ipc_pkg::OFS_EXT_CFG: rd_mux = {24'h00_0000, ext_cfg};
      ipc_pkg::OFS_PRIO_ONE: rd_mux = {{(32-NSRC){1'b0}}, prio_one};
      ipc_pkg::OFS_IRQ_STATUS: rd_mux = {28'h000_0000, irq_status};
      ipc_pkg::OFS_IRQ_MASK: rd_mux = {28'h000_0000, irq_mask};
      ipc_pkg::OFS_REQ_PEND: rd_mux = {{30{1'b0}}, EXT_B_REQ, EXT_A_REQ};
      ipc_pkg::OFS_GRANT: rd_mux = {{(31-NSRC){1'b0}}, CORE_GRANT_HIGH, CORE_GRANT};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      AVS_READDATA <= 32'h0000_0000;
      AVS_RESPONSE <= 2'h0;
    end else if (CLK_EN && (bus_state == ipc_pkg::BUS_IDLE) && (AVS_READ || AVS_WRITE)) begin
      AVS_READDATA <= rd_mux;
      AVS_RESPONSE <= hit ? 2'h0 : 2'h3;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      prio_one <= NSRC'(ipc_pkg::RST_PRIO_ONE);
    end else if (wr_hit && AVS_ADDRESS == ipc_pkg::OFS_PRIO_ONE) begin
      prio_one <= AVS_WRITEDATA[NSRC-1:0];
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      cmp_b_mode <= ipc_pkg::RST_CMP_B_MODE;
    end else if (wr_hit && AVS_ADDRESS == ipc_pkg::OFS_CMP_B_MODE) begin
      cmp_b_mode <= AVS_WRITEDATA[7:0] & 8'(ipc_pkg::CMP_B_WMASK);
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ext_cfg <= ipc_pkg::RST_EXT_CFG;
    end else if (wr_hit && AVS_ADDRESS == ipc_pkg::OFS_EXT_CFG) begin
      ext_cfg <= AVS_WRITEDATA[7:0];
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      irq_mask <= 4'h0;
    end else if (wr_hit && AVS_ADDRESS == ipc_pkg::OFS_IRQ_MASK) begin
      irq_mask <= AVS_WRITEDATA[3:0];
    end
  end

  assign CMP_B_RESP_MODE = cmp_b_mode[1:0];

  ////////////////////////////////////////////////////////////////////////////
  // External inputs
  ipc_pin_sel u_ext_a (
    .pins(PORT0_IN),
    .sel(ext_cfg[ipc_pkg::EXT_A_SEL_LSB +: 3]),
    .pol(ext_cfg[ipc_pkg::EXT_A_POL_BIT]),
    .active(ext_a_act)
  );

  ipc_pin_sel u_ext_b (
    .pins(PORT0_IN),
    .sel(ext_cfg[ipc_pkg::EXT_B_SEL_LSB +: 3]),
    .pol(ext_cfg[ipc_pkg::EXT_B_POL_BIT]),
    .active(ext_b_act)
  );

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      EXT_A_REQ <= 1'b0;
      EXT_B_REQ <= 1'b0;
    end else if (CLK_EN) begin
      EXT_A_REQ <= ext_a_act;
      EXT_B_REQ <= ext_b_act;
    end
  end

  // Routing: skipped pins are withheld from peripherals
  assign PERIPH_GRANT = PERIPH_WANT & ~PORT0_SKIP;

  ////////////////////////////////////////////////////////////////////////////
  // Comparator B edges and sticky status
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      cmp_b_q <= 1'b0;
    end else if (CLK_EN) begin
      cmp_b_q <= CMP_B_OUT;
    end
  end

  always_comb begin
    events = 4'h0;
    events[ipc_pkg::ST_EXT_A] = ext_a_act && !EXT_A_REQ;
    events[ipc_pkg::ST_EXT_B] = ext_b_act && !EXT_B_REQ;
    events[ipc_pkg::ST_CMP_RISE] = cmp_b_mode[ipc_pkg::CMP_B_RISE_BIT] && CMP_B_OUT && !cmp_b_q;
    events[ipc_pkg::ST_CMP_FALL] = cmp_b_mode[ipc_pkg::CMP_B_FALL_BIT] && !CMP_B_OUT && cmp_b_q;
  end

  always_comb begin
    next_status = irq_status;
    if (wr_hit && AVS_ADDRESS == ipc_pkg::OFS_IRQ_STATUS) begin
      next_status = next_status & ~AVS_WRITEDATA[3:0];
    end
    next_status = next_status | events;
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      irq_status <= ipc_pkg::RST_STATUS;
    end else if (CLK_EN) begin
      irq_status <= next_status;
    end
  end

  assign IRQ = |(irq_status & irq_mask);

  ////////////////////////////////////////////////////////////////////////////
  // Priority presentation to the core
  ipc_prio_arb #(
    .N(NSRC)
  ) u_arb (
    .req(SRC_REQ),
    .high(prio_one),
    .grant(arb_grant),
    .grant_high(arb_high)
  );

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      CORE_GRANT <= '0;
      CORE_GRANT_HIGH <= 1'b0;
    end else if (CLK_EN) begin
      CORE_GRANT <= arb_grant;
      CORE_GRANT_HIGH <= arb_high;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  sequence rise_seq;
    CLK_EN && !SYS_RST && cmp_b_mode[ipc_pkg::CMP_B_RISE_BIT] && CMP_B_OUT && !cmp_b_q;
  endsequence

  sequence bus_seen_seq;
    CLK_EN && !SYS_RST && (bus_state == ipc_pkg::BUS_IDLE) && (AVS_READ || AVS_WRITE);
  endsequence

  sequence bus_answer_seq;
    CLK_EN && !AVS_WAITREQUEST;
  endsequence

  bus_answer_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    bus_seen_seq ##1 CLK_EN |-> !AVS_WAITREQUEST)
    else $error("bus answer late");
  bus_gap_a: assert property (@(posedge CLK) disable iff (SYS_RST) bus_answer_seq |=> AVS_WAITREQUEST)
    else $error("bus answer held too long");
  bus_unmapped_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    bus_seen_seq ##0 !hit |=> AVS_RESPONSE == 2'h3)
    else $error("unmapped access not refused");
  grant_onehot_a: assert property (@(posedge CLK) disable iff (SYS_RST) $onehot0(CORE_GRANT))
    else $error("more than one grant");
  status_set_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    CLK_EN && !SYS_RST && (events != 4'h0) |=> (irq_status & $past(events)) == $past(events))
    else $error("event lost against clear");

  prio_reset_a: assert property (@(posedge CLK) $rose(!SYS_RST) |-> prio_one == '0)
    else $error("priority not zero after reset");
  mode_reset_a: assert property (@(posedge CLK) $rose(!SYS_RST) |-> cmp_b_mode == 8'h02)
    else $error("comparator mode reset wrong");
  cfg_reset_a: assert property (@(posedge CLK) $rose(!SYS_RST) |-> ext_cfg == 8'h01)
    else $error("pin config reset wrong");
  rise_flag_a: assert property (@(posedge CLK) disable iff (SYS_RST) rise_seq |=> irq_status[2])
    else $error("rise edge not flagged");
  fall_off_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    CLK_EN && !cmp_b_mode[4] && !irq_status[3] && !wr_hit |=> !irq_status[3])
    else $error("fall flag set while disabled");
  ext_a_req_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    CLK_EN && !SYS_RST |=> EXT_A_REQ == ($past(ext_cfg[3]) ~^ $past(PORT0_IN[ext_cfg[2:0]])))
    else $error("input A request wrong");
  ext_b_req_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    CLK_EN && !SYS_RST |=> EXT_B_REQ == ($past(ext_cfg[7]) ~^ $past(PORT0_IN[ext_cfg[6:4]])))
    else $error("input B request wrong");
  skip_route_a: assert property (@(posedge CLK) disable iff (SYS_RST) (PERIPH_GRANT & PORT0_SKIP) == 8'h00)
    else $error("skipped pin granted");
  high_first_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    CLK_EN && !SYS_RST && |(SRC_REQ & prio_one) |=> CORE_GRANT_HIGH && |(CORE_GRANT & $past(prio_one)))
    else $error("low request beat high");
endmodule // ipc_top
`default_nettype wire

/* hw/ipc_pkg.sv */
// Package of offsets, field positions, reset values and states for the interrupt configuration block
`default_nettype none
package ipc_pkg;
  // Register word byte addresses
  localparam logic [7:0] OFS_CMP_B_MODE = 8'h9c;
  localparam logic [7:0] OFS_EXT_CFG = 8'he4;
  localparam logic [7:0] OFS_PRIO_ONE = 8'h40;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h44;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h48;
  localparam logic [7:0] OFS_REQ_PEND = 8'h4c;
  localparam logic [7:0] OFS_GRANT = 8'h50;
  // Reset values
  localparam logic [7:0] RST_CMP_B_MODE = 8'h02;
  localparam logic [7:0] RST_EXT_CFG = 8'h01;
  localparam logic [7:0] RST_PRIO_ONE = 8'h00;
  localparam logic [3:0] RST_STATUS = 4'h0;
  // Field positions
  localparam int CMP_B_RISE_BIT = 5;
  localparam int CMP_B_FALL_BIT = 4;
  localparam int CMP_B_WMASK = 8'h33;
  localparam int EXT_B_POL_BIT = 7;
  localparam int EXT_B_SEL_LSB = 4;
  localparam int EXT_A_POL_BIT = 3;
  localparam int EXT_A_SEL_LSB = 0;
  // Status bit positions
  localparam int ST_EXT_A = 0;
  localparam int ST_EXT_B = 1;
  localparam int ST_CMP_RISE = 2;
  localparam int ST_CMP_FALL = 3;
  // Number of prioritised sources
  localparam int NUM_SRC = 8;
  // Bus slave states
  typedef enum logic [2:0] {
    BUS_IDLE = 3'b001,
    BUS_ACK = 3'b010,
    BUS_DONE = 3'b100
  } ipc_bus_t;
endpackage
`default_nettype wire

/* hw/ipc_pin_sel.sv */
// Port-0 pin selector with polarity for one external interrupt input
`timescale 1ns/100ps
`default_nettype none
module ipc_pin_sel (
  // Port pins and selection
  input wire logic [7:0] pins,
  input wire logic [2:0] sel,
  input wire logic pol,
  // Active request
  output logic active
);
  // Pin n for select n, read only; polarity 1 is active high
  assign active = pol ? pins[sel] : ~pins[sel];
endmodule // ipc_pin_sel
`default_nettype wire

/* hw/ipc_prio_arb.sv */
// Two-level priority arbiter over the prioritised interrupt sources
`timescale 1ns/100ps
`default_nettype none
module ipc_prio_arb #(
  parameter int N = 8
) (
  // Requests and levels
  input wire logic [N-1:0] req,
  input wire logic [N-1:0] high,
  // Grant
  output logic [N-1:0] grant,
  output logic grant_high
);
  logic [N-1:0] hi_req;
  logic [N-1:0] lo_req;
  logic [N-1:0] pick;
  assign hi_req = req & high;
  assign lo_req = req & ~high;
  // High-level requests win over low; among equals the lowest bit wins
  assign pick = (|hi_req) ? hi_req : lo_req;
  assign grant = pick & (~pick + {{(N-1){1'b0}}, 1'b1});
  assign grant_high = |hi_req;
endmodule // ipc_prio_arb
`default_nettype wire

/* tb/ipc_core_model.sv */
// Core-side model that holds source requests and drops each one once the core grants it
`timescale 1ns/100ps
`default_nettype none
module ipc_core_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Request loading and grants
  input wire logic load,
  input wire logic [7:0] load_val,
  input wire logic [7:0] grant,
  output logic [7:0] src_req
);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      src_req <= 8'h00;
    end else if (load) begin
      src_req <= load_val;
    end else begin
      src_req <= src_req & ~grant;
    end
  end
endmodule // ipc_core_model
`default_nettype wire

/* tb/ipc_top_tb.sv */
// Register, pin, interrupt and priority tests of the configuration block
`timescale 1ns/100ps
`default_nettype none
module ipc_top_tb;
  logic CLK = 1'b0;
  logic SYS_RST = 1'b1;
  logic CLK_EN = 1'b1;
  logic [7:0] AVS_ADDRESS = 8'h00;
  logic AVS_READ = 1'b0;
  logic AVS_WRITE = 1'b0;
  logic [31:0] AVS_WRITEDATA = 32'h0000_0000;
  logic [3:0] AVS_BYTEENABLE = 4'hf;
  logic [31:0] AVS_READDATA;
  logic AVS_WAITREQUEST;
  logic [1:0] AVS_RESPONSE;
  logic [7:0] PORT0_IN = 8'h00;
  logic [7:0] PORT0_SKIP = 8'h00;
  logic [7:0] PERIPH_WANT = 8'h00;
  logic [7:0] PERIPH_GRANT;
  logic CMP_B_OUT = 1'b0;
  logic [7:0] SRC_REQ;
  logic EXT_A_REQ;
  logic EXT_B_REQ;
  logic [7:0] CORE_GRANT;
  logic CORE_GRANT_HIGH;
  logic [1:0] CMP_B_RESP_MODE;
  logic IRQ;
  logic load = 1'b0;
  logic [7:0] load_val = 8'h00;
  int miscompares = 0;
  int compares = 0;
  int cyc = 0;
  logic [31:0] v;
  logic [1:0] r;
  logic [7:0] g;
  ipc_top #(.NSRC(8)) dut (.CLK(CLK), .SYS_RST(SYS_RST), .CLK_EN(CLK_EN), .AVS_ADDRESS(AVS_ADDRESS),
    .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .AVS_RESPONSE(AVS_RESPONSE),
    .PORT0_IN(PORT0_IN), .PORT0_SKIP(PORT0_SKIP), .PERIPH_WANT(PERIPH_WANT), .PERIPH_GRANT(PERIPH_GRANT),
    .CMP_B_OUT(CMP_B_OUT), .SRC_REQ(SRC_REQ), .EXT_A_REQ(EXT_A_REQ), .EXT_B_REQ(EXT_B_REQ),
    .CORE_GRANT(CORE_GRANT), .CORE_GRANT_HIGH(CORE_GRANT_HIGH), .CMP_B_RESP_MODE(CMP_B_RESP_MODE), .IRQ(IRQ));
  ipc_core_model core (.clk(CLK), .rst(SYS_RST), .load(load), .load_val(load_val), .grant(CORE_GRANT),
    .src_req(SRC_REQ));
  initial begin
    forever #25 CLK = ~CLK;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    if (miscompares == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    AVS_READ <= !wr;
    AVS_WRITE <= wr;
    @(negedge CLK);
    while (AVS_WAITREQUEST !== 1'b0) begin
      @(negedge CLK);
    end
    @(posedge CLK);
    v = AVS_READDATA;
    r = AVS_RESPONSE;
    AVS_READ <= 1'b0;
    AVS_WRITE <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk(v, exp);
  endtask
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      report_and_stop();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge CLK);
    SYS_RST <= 1'b0;
    rdchk(ipc_pkg::OFS_PRIO_ONE, 32'h0000_0000);
    rdchk(ipc_pkg::OFS_CMP_B_MODE, 32'h0000_0002);
    chk(CMP_B_RESP_MODE, 2'h2);
    rdchk(ipc_pkg::OFS_EXT_CFG, 32'h0000_0001);
    rdchk(8'h00, 32'h0000_0000);
    chk(r, 2'h3);
    bus(1'b1, 8'h00, 32'h0000_00ff);
    chk(r, 2'h3);
    bus(1'b1, ipc_pkg::OFS_PRIO_ONE, 32'h0000_00a5);
    rdchk(ipc_pkg::OFS_PRIO_ONE, 32'h0000_00a5);
    AVS_BYTEENABLE <= 4'he;
    bus(1'b1, ipc_pkg::OFS_PRIO_ONE, 32'h0000_00ff);
    AVS_BYTEENABLE <= 4'hf;
    rdchk(ipc_pkg::OFS_PRIO_ONE, 32'h0000_00a5);
    bus(1'b1, ipc_pkg::OFS_CMP_B_MODE, 32'h0000_00ff);
    rdchk(ipc_pkg::OFS_CMP_B_MODE, 32'h0000_0033);
    chk(CMP_B_RESP_MODE, 2'h3);
    // Pin select and polarity on both inputs, pins skipped from routing
    PORT0_IN <= 8'h5a;
    PORT0_SKIP <= 8'hff;
    PERIPH_WANT <= 8'hff;
    for (int p = 0; p < 2; p++) begin
      for (int n = 0; n < 8; n++) begin
        bus(1'b1, ipc_pkg::OFS_EXT_CFG, {24'h0, p[0], 3'(7 - n), p[0], 3'(n)});
        repeat (2) @(posedge CLK);
        chk(EXT_A_REQ, (PORT0_IN[n] == p[0]));
        chk(EXT_B_REQ, (PORT0_IN[7 - n] == p[0]));
      end
    end
    rdchk(ipc_pkg::OFS_EXT_CFG, 32'h0000_008f);
    chk(PERIPH_GRANT, 8'h00);
    PORT0_SKIP <= 8'h0f;
    @(posedge CLK);
    @(negedge CLK);
    chk(PERIPH_GRANT, 8'hf0);
    // Request view, then requests frozen while the clock enable is low
    @(posedge CLK);
    PORT0_IN <= 8'h81;
    rdchk(ipc_pkg::OFS_REQ_PEND, 32'h0000_0003);
    CLK_EN <= 1'b0;
    PORT0_IN <= 8'h00;
    repeat (3) @(posedge CLK);
    chk(EXT_A_REQ, 1'b1);
    CLK_EN <= 1'b1;
    repeat (2) @(posedge CLK);
    chk(EXT_A_REQ, 1'b0);
    // Comparator edge interrupts, status, mask and level output
    bus(1'b1, ipc_pkg::OFS_IRQ_STATUS, 32'h0000_000f);
    bus(1'b1, ipc_pkg::OFS_IRQ_MASK, 32'h0000_0004);
    bus(1'b1, ipc_pkg::OFS_CMP_B_MODE, 32'h0000_0020);
    CMP_B_OUT <= 1'b1;
    bus(1'b0, ipc_pkg::OFS_IRQ_STATUS, 32'h0000_0000);
    chk(v & 32'hc, 32'h0000_0004);
    chk(IRQ, 1'b1);
    bus(1'b1, ipc_pkg::OFS_IRQ_STATUS, 32'h0000_0004);
    CMP_B_OUT <= 1'b0;
    bus(1'b0, ipc_pkg::OFS_IRQ_STATUS, 32'h0000_0000);
    chk(v & 32'hc, 32'h0000_0000);
    chk(IRQ, 1'b0);
    bus(1'b1, ipc_pkg::OFS_CMP_B_MODE, 32'h0000_0010);
    CMP_B_OUT <= 1'b1;
    bus(1'b0, ipc_pkg::OFS_IRQ_STATUS, 32'h0000_0000);
    chk(v & 32'hc, 32'h0000_0000);
    CMP_B_OUT <= 1'b0;
    bus(1'b0, ipc_pkg::OFS_IRQ_STATUS, 32'h0000_0000);
    chk(v & 32'hc, 32'h0000_0008);
    chk(IRQ, 1'b0);
    // Two pending requests: the high one is granted first
    bus(1'b1, ipc_pkg::OFS_PRIO_ONE, 32'h0000_0040);
    load <= 1'b1;
    load_val <= 8'h41;
    @(posedge CLK);
    load <= 1'b0;
    g = 8'h00;
    for (int k = 0; k < 20 && g == 8'h00; k++) begin
      @(negedge CLK);
      g = CORE_GRANT;
    end
    chk(g, 8'h40);
    chk(CORE_GRANT_HIGH, 1'b1);
    for (int k = 0; k < 20 && (g == 8'h40 || g == 8'h00); k++) begin
      @(negedge CLK);
      g = CORE_GRANT;
    end
    chk(g, 8'h01);
    chk(CORE_GRANT_HIGH, 1'b0);
    // Reset in mid-run returns the registers to their reset values
    @(posedge CLK);
    SYS_RST <= 1'b1;
    repeat (2) @(posedge CLK);
    SYS_RST <= 1'b0;
    rdchk(ipc_pkg::OFS_EXT_CFG, 32'h0000_0001);
    rdchk(ipc_pkg::OFS_CMP_B_MODE, 32'h0000_0002);
    rdchk(ipc_pkg::OFS_PRIO_ONE, 32'h0000_0000);
    rdchk(ipc_pkg::OFS_GRANT, 32'h0000_0000);
    report_and_stop();
  end
endmodule // ipc_top_tb
`default_nettype wire
